/* pkg/uepf_regs.svh */
// register indices, field positions and sizes of the endpoint flag block
// assumes byte address = 4 * index on a 32-bit apb
`ifndef UEPF_REGS_SVH
`define UEPF_REGS_SVH
`define UEPF_NEP 4
`define UEPF_EPW 2
`define UEPF_MEM_DEPTH 512
`define UEPF_IDX_FLAGS 10'h0e8
`define UEPF_IDX_CFG 10'h0e9
`define UEPF_IDX_SEL 10'h0ea
`define UEPF_IDX_ISO 10'h0ee
`define UEPF_IDX_EN 10'h0f0
`define UEPF_IDX_PORT 10'h0f1
`define UEPF_IDX_TALLY 10'h0f2
`define UEPF_F_HANDOVER 3'h7
`define UEPF_F_NAKIN 3'h6
`define UEPF_F_ACCESS 3'h5
`define UEPF_F_NAKOUT 3'h4
`define UEPF_F_SETUP 3'h3
`define UEPF_F_OUTPKT 3'h2
`define UEPF_F_STALL 3'h1
`define UEPF_F_TXRDY 3'h0
`define UEPF_E_FLOW 3'h7
`define UEPF_ISO_OVR 3'h6
`define UEPF_ISO_UND 3'h5
`define UEPF_CFG_DIR 3'h2
`define UEPF_CFG_STALL_REQUEST 3'h3
`define UEPF_RSVD_MASK 8'hdf
`define UEPF_IRQ_MASK 8'h5f
`define UEPF_ACCESS_BIT 8'h20
`define UEPF_BANK_BYTES 8'h40
`define UEPF_ZERO_BYTE 8'h00
`define UEPF_ONE_BYTE 8'h01
`endif

/* pkg/uepf_pkg.sv */
// types of the endpoint flag block
// assumes uepf_regs.svh sits on the include path
`include "uepf_regs.svh"
package uepf_pkg;
  typedef enum logic [1:0] {EP_CTRL = 2'b00, EP_ISO = 2'b01, EP_BULK = 2'b10, EP_INTR = 2'b11} uepf_eptype_t;
  typedef enum logic {APB_WAIT = 1'b0, APB_ACK = 1'b1} uepf_apb_t;
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] enables;
    logic overrun;
    logic underrun;
    uepf_eptype_t epType;
    logic dirIn;
    logic stallReq;
    logic cpuBank;
    logic usbBank;
    logic [1:0] busy;
    logic announced;
    logic setupPend;
    logic [1:0][7:0] tally;
    logic [5:0] rdIdx;
  } uepf_ep_t;
  typedef struct packed {
    uepf_ep_t [`UEPF_NEP-1:0] ep;
    logic [`UEPF_EPW-1:0] epSel;
    logic [6:0] rxIdx;
    logic [5:0] txIdx;
    uepf_apb_t phase;
    logic pready;
    logic pslverr;
    logic [7:0] rdata;
    logic [7:0] txByte;
    logic irq;
  } uepf_state_t;
endpackage

/* rtl/uepf_endpoint.sv */
// endpoint flags, enables, two-bank byte port and byte tally, apb slave
// assumes the usb engine drives its event pulses synchronous to clk_sys
//
// Function
// - out/setup stored: handover and flag together
// - out handover cleared: free bank, advance
// - in bank free: handover and transmit-ready together
// - in handover cleared: commit bank, advance
// - nak to in token sets flag
// - nak to out token sets flag
// - flags cleared by zero, one ignored
// - access ok: in room or out data
// - access ok low on stall request, errors
// - setup flag only for error-free setup
// - out flag when bank holds new packet
// - in: writing one aborts last loaded bank
// - stall flag on stall sent, iso crc error
// - transmit ready when current bank free
// - irq needs flag, enable and global flag
// - flow enable gates overrun and underrun
// - reserved enable bit reads zero
// - port write appends byte to bank
// - port read pops next bank byte
// - tally counts bytes loaded, push increments
// - out tally decrements per port read
// - iso overrun and underrun set error flags
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "uepf_regs.svh"
module uepf_endpoint import uepf_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic globalIrqOn,
  input wire logic [`UEPF_EPW-1:0] usbEp,
  input wire logic nakInSent,
  input wire logic nakOutSent,
  input wire logic stallSent,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic pktDone,
  input wire logic pktSetup,
  input wire logic pktOk,
  input wire logic txReq,
  input wire logic inDone,
  output logic [7:0] txByte,
  output logic epIrq
);

  uepf_state_t st_q;
  uepf_state_t st_d;
  logic [7:0] mem [0:`UEPF_MEM_DEPTH-1];
  logic cpuWe;
  logic [8:0] cpuWa;
  logic usbWe;
  logic [8:0] usbWa;
  logic access;
  logic wrOk;
  logic rdOk;
  logic [7:0] keep;
  logic [7:0] rdMux;
  logic irqAny;
  logic pushSel;
  logic popSel;
  logic relSel;
  logic cb;
  logic ub;

  function automatic logic isReg(input logic [11:0] a, input logic [9:0] idx);
    return a[11:2] == idx;
  endfunction

  function automatic logic isInEp(input uepf_ep_t e);
    return e.dirIn && (e.epType != EP_CTRL);
  endfunction

  function automatic logic accessOk(input uepf_ep_t e);
    if (e.epType == EP_CTRL || e.stallReq || e.overrun || e.underrun) begin
      return 1'b0;
    end
    if (e.dirIn) begin
      return !e.busy[e.cpuBank] && (e.tally[e.cpuBank] < `UEPF_BANK_BYTES);
    end
    return e.busy[e.cpuBank] && (e.tally[e.cpuBank] != `UEPF_ZERO_BYTE);
  endfunction

  always_comb begin
    st_d = st_q;
    cpuWe = 1'b0;
    cpuWa = '0;
    usbWe = 1'b0;
    usbWa = '0;
    keep = '0;
    rdMux = '0;
    irqAny = 1'b0;
    pushSel = 1'b0;
    popSel = 1'b0;
    relSel = 1'b0;
    cb = 1'b0;
    ub = 1'b0;
    access = psel && penable && (st_q.phase == APB_WAIT);
    wrOk = access && pwrite && pstrb[0];
    rdOk = access && !pwrite;
    st_d.pready = 1'b0;
    st_d.pslverr = 1'b0;
    if (psel && penable && (st_q.phase == APB_ACK)) begin
      st_d.phase = APB_WAIT;
    end
    // read data of the selected endpoint
    if (isReg(paddr, `UEPF_IDX_FLAGS)) begin
      rdMux = st_q.ep[st_q.epSel].flags & `UEPF_RSVD_MASK;
      rdMux[`UEPF_F_ACCESS] = accessOk(st_q.ep[st_q.epSel]);
    end else if (isReg(paddr, `UEPF_IDX_EN)) begin
      rdMux = st_q.ep[st_q.epSel].enables & `UEPF_RSVD_MASK;
    end else if (isReg(paddr, `UEPF_IDX_PORT)) begin
      rdMux = mem[{st_q.epSel, st_q.ep[st_q.epSel].cpuBank, st_q.ep[st_q.epSel].rdIdx}];
    end else if (isReg(paddr, `UEPF_IDX_TALLY)) begin
      rdMux = st_q.ep[st_q.epSel].tally[st_q.ep[st_q.epSel].cpuBank];
    end else if (isReg(paddr, `UEPF_IDX_CFG)) begin
      rdMux = {4'h0, st_q.ep[st_q.epSel].stallReq, st_q.ep[st_q.epSel].dirIn, st_q.ep[st_q.epSel].epType};
    end else if (isReg(paddr, `UEPF_IDX_SEL)) begin
      rdMux = {6'h00, st_q.epSel};
    end else if (isReg(paddr, `UEPF_IDX_ISO)) begin
      rdMux = {1'b0, st_q.ep[st_q.epSel].overrun, st_q.ep[st_q.epSel].underrun, 5'h00};
    end
    if (access) begin
      st_d.phase = APB_ACK;
      st_d.pready = 1'b1;
      st_d.rdata = pwrite ? `UEPF_ZERO_BYTE : rdMux;
      st_d.pslverr = !(isReg(paddr, `UEPF_IDX_FLAGS) || isReg(paddr, `UEPF_IDX_EN) ||
        isReg(paddr, `UEPF_IDX_PORT) || isReg(paddr, `UEPF_IDX_TALLY) || isReg(paddr, `UEPF_IDX_CFG) ||
        isReg(paddr, `UEPF_IDX_SEL) || isReg(paddr, `UEPF_IDX_ISO));
    end
    if (wrOk && isReg(paddr, `UEPF_IDX_SEL)) begin
      st_d.epSel = pwdata[`UEPF_EPW-1:0];
    end
    for (int i = 0; i < `UEPF_NEP; i++) begin
      cb = st_q.ep[i].cpuBank;
      // firmware side, only for the selected endpoint
      if (`UEPF_EPW'(i) == st_q.epSel) begin
        if (wrOk && isReg(paddr, `UEPF_IDX_FLAGS)) begin
          keep = pwdata[7:0] | `UEPF_ACCESS_BIT;
          if (isInEp(st_q.ep[i])) begin
            keep[`UEPF_F_OUTPKT] = 1'b1;
          end
          st_d.ep[i].flags = st_q.ep[i].flags & keep;
          if (!pwdata[`UEPF_F_HANDOVER] && st_q.ep[i].flags[`UEPF_F_HANDOVER]) begin
            relSel = 1'b1;
            st_d.ep[i].busy[cb] = isInEp(st_q.ep[i]);
            if (!isInEp(st_q.ep[i])) begin
              st_d.ep[i].tally[cb] = `UEPF_ZERO_BYTE;
            end
            st_d.ep[i].cpuBank = !cb;
            st_d.ep[i].announced = 1'b0;
            st_d.ep[i].rdIdx = '0;
          end
          if (isInEp(st_q.ep[i]) && pwdata[`UEPF_F_OUTPKT] && st_q.ep[i].busy[!cb]) begin
            st_d.ep[i].busy[!cb] = 1'b0;
            st_d.ep[i].tally[!cb] = `UEPF_ZERO_BYTE;
            st_d.ep[i].usbBank = cb;
          end
        end
        if (wrOk && isReg(paddr, `UEPF_IDX_EN)) begin
          st_d.ep[i].enables = pwdata[7:0] & `UEPF_RSVD_MASK;
        end
        if (wrOk && isReg(paddr, `UEPF_IDX_ISO)) begin
          st_d.ep[i].overrun = st_q.ep[i].overrun & pwdata[`UEPF_ISO_OVR];
          st_d.ep[i].underrun = st_q.ep[i].underrun & pwdata[`UEPF_ISO_UND];
        end
        if (wrOk && isReg(paddr, `UEPF_IDX_CFG)) begin
          st_d.ep[i].epType = uepf_eptype_t'(pwdata[1:0]);
          st_d.ep[i].dirIn = pwdata[`UEPF_CFG_DIR];
          st_d.ep[i].stallReq = pwdata[`UEPF_CFG_STALL_REQUEST];
        end
        if (wrOk && isReg(paddr, `UEPF_IDX_PORT) && !st_q.ep[i].busy[cb] &&
            (st_q.ep[i].tally[cb] < `UEPF_BANK_BYTES)) begin
          pushSel = 1'b1;
          cpuWe = 1'b1;
          cpuWa = {st_q.epSel, cb, st_q.ep[i].tally[cb][5:0]};
          st_d.ep[i].tally[cb] = st_q.ep[i].tally[cb] + `UEPF_ONE_BYTE;
        end
        if (rdOk && isReg(paddr, `UEPF_IDX_PORT) && st_q.ep[i].busy[cb] &&
            (st_q.ep[i].tally[cb] != `UEPF_ZERO_BYTE)) begin
          popSel = 1'b1;
          st_d.ep[i].rdIdx = st_q.ep[i].rdIdx + 6'h01;
          st_d.ep[i].tally[cb] = st_q.ep[i].tally[cb] - `UEPF_ONE_BYTE;
        end
      end
      // usb engine side; sets come after clears so a set wins
      if (`UEPF_EPW'(i) == usbEp) begin
        ub = st_d.ep[i].usbBank;
        if (nakInSent) begin
          st_d.ep[i].flags[`UEPF_F_NAKIN] = 1'b1;
        end
        if (nakOutSent) begin
          st_d.ep[i].flags[`UEPF_F_NAKOUT] = 1'b1;
        end
        if (stallSent) begin
          st_d.ep[i].flags[`UEPF_F_STALL] = 1'b1;
        end
        if (rxValid) begin
          if (!st_d.ep[i].busy[ub] && ({1'b0, st_q.rxIdx} < `UEPF_BANK_BYTES)) begin
            usbWe = 1'b1;
            usbWa = {usbEp, ub, st_q.rxIdx[5:0]};
            st_d.rxIdx = st_q.rxIdx + 7'h01;
          end else if (st_q.ep[i].epType == EP_ISO) begin
            st_d.ep[i].overrun = 1'b1;
          end
        end
        if (pktDone) begin
          st_d.rxIdx = '0;
          if (pktOk && !st_d.ep[i].busy[ub]) begin
            st_d.ep[i].busy[ub] = 1'b1;
            st_d.ep[i].tally[ub] = {1'b0, st_q.rxIdx};
            st_d.ep[i].usbBank = !ub;
            st_d.ep[i].setupPend = pktSetup;
          end else if (!pktOk && (st_q.ep[i].epType == EP_ISO) && !st_q.ep[i].dirIn) begin
            st_d.ep[i].flags[`UEPF_F_STALL] = 1'b1;
          end
        end
        if (txReq) begin
          if (st_d.ep[i].busy[ub]) begin
            st_d.txByte = mem[{usbEp, ub, st_q.txIdx}];
            st_d.txIdx = st_q.txIdx + 6'h01;
          end else if (st_q.ep[i].epType == EP_ISO) begin
            st_d.ep[i].underrun = 1'b1;
          end
        end
        if (inDone && st_d.ep[i].busy[ub]) begin
          st_d.ep[i].busy[ub] = 1'b0;
          st_d.ep[i].tally[ub] = `UEPF_ZERO_BYTE;
          st_d.ep[i].usbBank = !ub;
          st_d.txIdx = '0;
        end
      end
      // hand the current bank to firmware once
      if (!st_d.ep[i].announced) begin
        if (!isInEp(st_d.ep[i]) && st_d.ep[i].busy[st_d.ep[i].cpuBank]) begin
          st_d.ep[i].announced = 1'b1;
          st_d.ep[i].flags[`UEPF_F_HANDOVER] = 1'b1;
          if (st_d.ep[i].setupPend) begin
            st_d.ep[i].flags[`UEPF_F_SETUP] = 1'b1;
          end else begin
            st_d.ep[i].flags[`UEPF_F_OUTPKT] = 1'b1;
          end
          st_d.ep[i].setupPend = 1'b0;
        end else if (isInEp(st_d.ep[i]) && !st_d.ep[i].busy[st_d.ep[i].cpuBank]) begin
          st_d.ep[i].announced = 1'b1;
          st_d.ep[i].flags[`UEPF_F_HANDOVER] = 1'b1;
          st_d.ep[i].flags[`UEPF_F_TXRDY] = 1'b1;
        end
      end
      // interrupt request from flags gated by enables
      if (((st_q.ep[i].flags & st_q.ep[i].enables & `UEPF_IRQ_MASK) != `UEPF_ZERO_BYTE) ||
          (st_q.ep[i].enables[`UEPF_E_FLOW] && (st_q.ep[i].overrun || st_q.ep[i].underrun))) begin
        irqAny = 1'b1;
      end
    end
    st_d.irq = irqAny && globalIrqOn;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (cpuWe) begin
      mem[cpuWa] <= pwdata[7:0];
    end
    if (usbWe) begin
      mem[usbWa] <= rxByte;
    end
  end

  assign prdata = {24'h000000, st_q.rdata};
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign txByte = st_q.txByte;
  assign epIrq = st_q.irq;

  sequence sq_read_en;
    psel && penable && !pwrite && (st_q.phase == APB_WAIT) && isReg(paddr, `UEPF_IDX_EN);
  endsequence

  sequence sq_read_flags_stalled;
    psel && penable && !pwrite && (st_q.phase == APB_WAIT) && isReg(paddr, `UEPF_IDX_FLAGS) &&
      st_q.ep[st_q.epSel].stallReq;
  endsequence

  nak_in_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    nakInSent |=> st_q.ep[$past(usbEp)].flags[`UEPF_F_NAKIN])
    else $error("nak in flag not set");

  nak_out_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    nakOutSent |=> st_q.ep[$past(usbEp)].flags[`UEPF_F_NAKOUT])
    else $error("nak out flag not set");

  stall_flag_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    stallSent |=> st_q.ep[$past(usbEp)].flags[`UEPF_F_STALL])
    else $error("stall flag not set");

  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    epIrq |-> $past(globalIrqOn))
    else $error("irq raised without global flag");

  en_rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    sq_read_en |=> pready && !prdata[5])
    else $error("reserved enable bit read as one");

  access_block_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    sq_read_flags_stalled |=> pready && !prdata[5])
    else $error("access flag high under stall request");

  push_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    pushSel |=> st_q.ep[st_q.epSel].tally[st_q.ep[st_q.epSel].cpuBank] ==
      $past(st_q.ep[st_q.epSel].tally[st_q.ep[st_q.epSel].cpuBank]) + `UEPF_ONE_BYTE)
    else $error("tally not incremented by push");

  pop_count_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    popSel |=> st_q.ep[st_q.epSel].tally[st_q.ep[st_q.epSel].cpuBank] ==
      $past(st_q.ep[st_q.epSel].tally[st_q.ep[st_q.epSel].cpuBank]) - `UEPF_ONE_BYTE)
    else $error("tally not decremented by pop");

  handover_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    relSel |=> st_q.ep[st_q.epSel].cpuBank != $past(st_q.ep[st_q.epSel].cpuBank))
    else $error("bank not advanced on handover release");

  sequence sq_bank_kill;
    wrOk && isReg(paddr, `UEPF_IDX_FLAGS) && pwdata[`UEPF_F_OUTPKT] && pwdata[`UEPF_F_HANDOVER] &&
      isInEp(st_q.ep[st_q.epSel]);
  endsequence

  sequence sq_bad_pkt;
    pktDone && !pktOk;
  endsequence

  bank_kill_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    sq_bank_kill |=> !st_q.ep[st_q.epSel].busy[!st_q.ep[st_q.epSel].cpuBank])
    else $error("killed bank still busy");

  // per-endpoint checks
  for (genvar g = 0; g < `UEPF_NEP; g++) begin : gEpChk
    handover_pair_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(st_q.ep[g].flags[`UEPF_F_HANDOVER]) |->
        (isInEp(st_q.ep[g]) ? st_q.ep[g].flags[`UEPF_F_TXRDY] :
          (st_q.ep[g].flags[`UEPF_F_SETUP] || st_q.ep[g].flags[`UEPF_F_OUTPKT])))
      else $error("handover set without its companion flag");

    tally_bound_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      (st_q.ep[g].tally[0] <= `UEPF_BANK_BYTES) && (st_q.ep[g].tally[1] <= `UEPF_BANK_BYTES))
      else $error("bank tally beyond bank size");

    setup_ok_only_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      sq_bad_pkt ##0 ((usbEp == `UEPF_EPW'(g)) && !(relSel && (st_q.epSel == `UEPF_EPW'(g)))) |=>
        !$rose(st_q.ep[g].flags[`UEPF_F_SETUP]))
      else $error("setup flag set by a damaged packet");

    iso_crc_stall_a: assert property (@(posedge clk_sys) disable iff (!resetn)
      sq_bad_pkt ##0 ((usbEp == `UEPF_EPW'(g)) && (st_q.ep[g].epType == EP_ISO) && !st_q.ep[g].dirIn) |=>
        st_q.ep[g].flags[`UEPF_F_STALL])
      else $error("iso crc error did not set stall flag");
  end

endmodule

/* tb/uepf_host_model.sv */
// usb host side model: token events, out packets, in fetches
// assumes its tasks are called just after a rising clk_sys edge
`timescale 1ns/10ps
`include "uepf_regs.svh"
module uepf_host_model (
  input wire logic clk_sys,
  output logic [`UEPF_EPW-1:0] usbEp,
  output logic nakInSent,
  output logic nakOutSent,
  output logic stallSent,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic pktDone,
  output logic pktSetup,
  output logic pktOk,
  output logic txReq,
  output logic inDone
);
  initial begin
    {usbEp, nakInSent, nakOutSent, stallSent, rxValid, rxByte, pktDone, pktSetup, pktOk, txReq, inDone} = '0;
  end
  // one-cycle event: 0 nak in, 1 nak out, 2 stall, 3 fetch, 4 bank taken
  task automatic ev(input logic [1:0] ep, input int k);
    usbEp <= ep;
    nakInSent <= (k == 0);
    nakOutSent <= (k == 1);
    stallSent <= (k == 2);
    txReq <= (k == 3);
    inDone <= (k == 4);
    @(posedge clk_sys);
    {nakInSent, nakOutSent, stallSent, txReq, inDone} <= '0;
    @(posedge clk_sys);
  endtask
  // bytes b0, b0+1, ... then packet end; data line inverted once at packet end
  task automatic pkt(input logic [1:0] ep, input logic [7:0] b0, input int n, input logic setup, input logic ok);
    usbEp <= ep;
    for (int i = 0; i < n; i++) begin
      rxValid <= 1'b1;
      rxByte <= b0 + 8'(i);
      @(posedge clk_sys);
    end
    rxValid <= 1'b0;
    rxByte <= ~rxByte;
    pktDone <= 1'b1;
    pktSetup <= setup;
    pktOk <= ok;
    @(posedge clk_sys);
    pktDone <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

/* tb/test_usb_endpoint_flags_and_fifo_port.sv */
// self-checking bench of the endpoint flag block over apb
// assumes uepf_endpoint and uepf_host_model are compiled before it
`timescale 1ns/10ps
`include "uepf_regs.svh"
module test_usb_endpoint_flags_and_fifo_port import uepf_pkg::*;;
  localparam logic [9:0] iFl = `UEPF_IDX_FLAGS;
  localparam logic [9:0] iEn = `UEPF_IDX_EN;
  localparam logic [9:0] iTy = `UEPF_IDX_TALLY;
  localparam logic [9:0] iPt = `UEPF_IDX_PORT;
  localparam logic [9:0] iSl = `UEPF_IDX_SEL;
  localparam logic [9:0] iCf = `UEPF_IDX_CFG;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, globalIrqOn, pready, pslverr, epIrq, gerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] txByte, rxByte, got, b0, q[$];
  logic [1:0] usbEp;
  logic nakInSent, nakOutSent, stallSent, rxValid, pktDone, pktSetup, pktOk, txReq, inDone;
  logic [15:0] seed = 16'he87d;
  int failures = 0;
  int check_count = 0;
  int n;
  always #4 clk_sys = ~clk_sys;
  uepf_endpoint dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .globalIrqOn(globalIrqOn), .usbEp(usbEp), .nakInSent(nakInSent), .nakOutSent(nakOutSent),
    .stallSent(stallSent), .rxValid(rxValid), .rxByte(rxByte), .pktDone(pktDone), .pktSetup(pktSetup),
    .pktOk(pktOk), .txReq(txReq), .inDone(inDone), .txByte(txByte), .epIrq(epIrq));
  uepf_host_model host (.clk_sys(clk_sys), .usbEp(usbEp), .nakInSent(nakInSent), .nakOutSent(nakOutSent),
    .stallSent(stallSent), .rxValid(rxValid), .rxByte(rxByte), .pktDone(pktDone), .pktSetup(pktSetup),
    .pktOk(pktOk), .txReq(txReq), .inDone(inDone));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] pktFlags(input logic setup, input logic ctrl);
    return 8'h80 | (setup ? 8'h08 : 8'h04) | (ctrl ? 8'h00 : `UEPF_ACCESS_BIT);
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // setup cycle, then access until pready; idle edge first
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
      if (k > 20) begin
        failures++;
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    got = prdata[7:0];
    gerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rc(input logic [9:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(got, e);
  endtask
  initial begin
    {psel, penable, pwrite, globalIrqOn} = '0;
    pstrb = 4'hf;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rc(iFl, 8'h00);
    rc(iEn, 8'h00);
    rc(iTy, 8'h00);
    apb(1'b0, 10'h000, 8'h00);
    chk({7'h0, gerr}, 8'h01);
    host.pkt(2'd0, 8'h11, 4, 1'b1, 1'b0);
    rc(iFl, 8'h00);
    host.pkt(2'd0, 8'h20, 8, 1'b1, 1'b1);
    rc(iFl, pktFlags(1'b1, 1'b1));
    rc(iTy, 8'h08);
    wr(iFl, 8'h00);
    rc(iFl, 8'h00);
    wr(iSl, 8'h01);
    wr(iCf, 8'h02);
    wr(iEn, 8'hff);
    rc(iEn, 8'hdf);
    pstrb <= 4'he;
    wr(iEn, 8'h00);
    pstrb <= 4'hf;
    rc(iEn, 8'hdf);
    seed = lfsr(seed);
    n = 1 + int'(seed[2:0]);
    b0 = seed[15:8];
    host.pkt(2'd1, b0, n, 1'b0, 1'b1);
    rc(iFl, pktFlags(1'b0, 1'b0));
    rc(iTy, 8'(n));
    for (int i = 0; i < n; i++) begin
      rc(iPt, b0 + 8'(i));
    end
    rc(iTy, 8'h00);
    rc(iFl, 8'h84);
    wr(iFl, 8'hff);
    rc(iFl, 8'h84);
    wr(iFl, 8'h00);
    rc(iFl, 8'h00);
    for (int k = 0; k < 3; k++) begin
      host.ev(2'd1, k);
    end
    rc(iFl, 8'h52);
    chk({7'h0, epIrq}, 8'h00);
    globalIrqOn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({7'h0, epIrq}, 8'h01);
    wr(iEn, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, epIrq}, 8'h00);
    wr(iFl, 8'h00);
    wr(iSl, 8'h02);
    wr(iCf, 8'h06);
    rc(iFl, 8'ha1);
    seed = lfsr(seed);
    n = 1 + int'(seed[2:0]);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      wr(iPt, seed[7:0]);
    end
    rc(iTy, 8'(n));
    wr(iCf, 8'h0e);
    rc(iFl, 8'h81);
    wr(iCf, 8'h06);
    wr(iFl, 8'h00);
    rc(iTy, 8'h00);
    foreach (q[i]) begin
      host.ev(2'd2, 3);
      chk(txByte, q[i]);
    end
    host.ev(2'd2, 4);
    for (int i = 0; i < 3; i++) begin
      wr(iPt, 8'h5a);
    end
    wr(iFl, 8'h00);
    wr(iFl, 8'h84);
    host.ev(2'd2, 3);
    chk(txByte, q[n-1]);
    wr(iSl, 8'h03);
    wr(iCf, 8'h05);
    wr(iEn, 8'h80);
    host.ev(2'd3, 3);
    rc(`UEPF_IDX_ISO, 8'h20);
    chk({7'h0, epIrq}, 8'h01);
    wr(`UEPF_IDX_ISO, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, epIrq}, 8'h00);
    wr(iCf, 8'h01);
    host.pkt(2'd3, b0, 2, 1'b0, 1'b0);
    rc(iFl, 8'h83);
    tally_and_finish();
  end
endmodule
